/* hw/mbs_pkg.sv */
// package: buffer word map, config map, status fields, host map
// assumes 16-bit buffer words and a host that addresses words, not bytes
`default_nettype none
package mbs_pkg;
  // words inside one message buffer
  localparam logic [4:0] W_HDR = 5'h00;
  localparam logic [4:0] W_LEN = 5'h01;
  localparam logic [4:0] W_CRC = 5'h02;
  localparam logic [4:0] W_DATA0 = 5'h03;
  localparam logic [4:0] W_STS = 5'h13;
  localparam int DATA_WORDS = 16;
  localparam logic [6:0] MAX_LEN = 7'h10;
  // config words, reached with cfg high
  localparam logic [4:0] C_SPL = 5'h00;
  localparam logic [4:0] C_DPL = 5'h01;
  localparam logic [4:0] C_SYNC = 5'h02;
  localparam logic [4:0] C_KIND0 = 5'h03;
  localparam int MAX_BUF = 29;
  localparam logic [6:0] SPL_RESET = 7'h08;
  localparam logic [6:0] DPL_RESET = 7'h10;
  localparam logic [15:0] SYNC_RESET = 16'h0000;
  // header word fields
  localparam int H_PP = 14;
  localparam int H_NFI = 13;
  localparam int H_SYNC = 12;
  localparam int H_SUP = 11;
  localparam int SYNC_SUP_BIT = 15;
  // slot status fields
  localparam int S_TX_CONFLICT_FLAG = 0;
  localparam int S_CH = 8;
  localparam logic [8:0] STS_RESET = 9'h000;
  // buffer kinds
  typedef enum logic [1:0] {
    MBS_RX = 2'b00,
    MBS_FIFO = 2'b01,
    MBS_TXS = 2'b10,
    MBS_TXD = 2'b11
  } mbs_kind_t;
  // header check code
  localparam logic [10:0] CRC_POLY = 11'h385;
  localparam logic [10:0] CRC_INIT = 11'h01a;
  localparam logic [4:0] HDR_BITS = 5'h14;
  // host controller own registers (addr bit 9 high)
  localparam logic [8:0] R_HID = 9'h000;
  localparam logic [8:0] R_HLEN = 9'h001;
  localparam logic [8:0] R_HGO = 9'h002;
  localparam logic [8:0] R_HSTAT = 9'h003;
  localparam logic [8:0] R_HEADER_CHECK_CODE = 9'h004;
endpackage
`default_nettype wire

/* hw/mbs_if.sv */
// buffer access link between the host controller and the buffer/slot status device
// assumes one clock; read data stand one cycle after the read strobe
`default_nettype none
interface mbs_if #(parameter int BUF_W = 3);
  logic cfg;
  logic [BUF_W-1:0] buf_sel;
  logic [4:0] word;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic static_length_mismatch_irq;
  logic dynamic_length_excess_irq;
  modport dev (input cfg, buf_sel, word, wdata, wr, rd,
    output rdata, static_length_mismatch_irq, dynamic_length_excess_irq);
  modport host (output cfg, buf_sel, word, wdata, wr, rd,
    input rdata, static_length_mismatch_irq, dynamic_length_excess_irq);
endinterface
`default_nettype wire

/* hw/mbs_header_check_code.sv */
// serial 11-bit header check code over sync, startup, frame id and payload length
// assumes start is a one-cycle pulse and inputs are steady on that cycle
`default_nettype none
module mbs_header_check_code (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic sync_bit,
  input wire logic startup_bit,
  input wire logic [10:0] frame_id,
  input wire logic [6:0] payload_word_count,
  output logic busy,
  output logic done,
  output logic [10:0] header_check_code
);
  logic [19:0] shift_reg;
  logic [4:0] cnt_reg;
  logic fb;

  ////////////////////////////////////////////////////////////////////////////
  // one header bit per clock, msb first; 20 cycles is cheap next to a slot
  assign fb = shift_reg[19] ^ header_check_code[10];

  always_ff @(posedge clk) begin
    if (reset) begin
      shift_reg <= 20'h00000;
      cnt_reg <= 5'h00;
      busy <= 1'b0;
      done <= 1'b0;
      header_check_code <= mbs_pkg::CRC_INIT;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        shift_reg <= {sync_bit, startup_bit, frame_id, payload_word_count}; // R5
        cnt_reg <= 5'h00;
        busy <= 1'b1;
        header_check_code <= mbs_pkg::CRC_INIT;
      end else if (busy) begin
        shift_reg <= {shift_reg[18:0], 1'b0};
        header_check_code <= {header_check_code[9:0], 1'b0} ^ (fb ? mbs_pkg::CRC_POLY : 11'h000);
        cnt_reg <= cnt_reg + 5'h01;
        if (cnt_reg == mbs_pkg::HDR_BITS - 5'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // mbs_header_check_code
`default_nettype wire

/* hw/mbs_engine.sv */
// message buffer store with slot status update, device end of the buffer link
// assumes one slot_done pulse per slot, outcome inputs valid with it
//
// Overview of operation
// (R1) payload length counts 16-bit words
// (R2) static tx length mismatch raises interrupt
// (R3) dynamic tx length over limit raises interrupt
// (R4) payload never exceeds 32 bytes
// (R5) check code covers sync, startup, id, length
// (R6) rx check code stored only for valid frames
// (R7) host supplies tx check code, sent unchecked
// (R8) rx sync/startup change only on stored frame
// (R9) tx sync/startup come from sync slot register
// (R10) status word: channel bit 8, flags 7..0
// (R11) tx updates conflict flag only, rx the rest
// (R12) null/invalid frame writes status word only
// (R13) valid frame writes status and all fields
// (R14) update done within next slot's first macrotick
// (R15) empty slot reads 0x0000 A, 0x0100 B
// (R16) conflict flag when reception precedes transmit start
// (R17) boundary flag on activity at slot edges
// (R18) content and syntax error flags
// (R19) startup, null, sync flags from correct header
// (R20) valid element flag on correct frame or symbol
// (R21) channel flag 0 for A, 1 for B
// (R22) fifo stores only filtered, unmatched frames
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`default_nettype none
module mbs_engine #(
  parameter int NUM_BUF = 8,
  parameter int BUF_W = 3
) (
  input wire logic clk,
  input wire logic reset,
  mbs_if.dev mb,
  input wire logic [10:0] pe_slot_id,
  output logic pe_tx_sync,
  output logic pe_tx_startup,
  input wire logic pe_rx_word_valid,
  input wire logic [15:0] pe_rx_word,
  input wire logic pe_slot_done,
  input wire logic pe_buf_hit,
  input wire logic [BUF_W-1:0] pe_buf,
  input wire logic pe_channel,
  input wire logic pe_frame_seen,
  input wire logic pe_symbol_ok,
  input wire logic pe_syntax_ok,
  input wire logic pe_content_ok,
  input wire logic pe_boundary,
  input wire logic pe_tx_conflict,
  input wire logic pe_hdr_pp,
  input wire logic pe_hdr_null,
  input wire logic pe_hdr_sync,
  input wire logic pe_hdr_startup,
  input wire logic [10:0] pe_hdr_id,
  input wire logic [5:0] pe_hdr_cycle,
  input wire logic [6:0] pe_hdr_len,
  input wire logic [10:0] pe_hdr_crc,
  input wire logic pe_acc_pass,
  input wire logic pe_rej_hit,
  input wire logic pe_ded_match,
  input wire logic pe_tx_rd,
  input wire logic [BUF_W-1:0] pe_tx_buf,
  input wire logic [3:0] pe_tx_word,
  output logic [15:0] pe_tx_data,
  output logic [6:0] pe_tx_len,
  output logic [10:0] pe_tx_crc,
  output logic pe_update_done
);
  localparam int DW = mbs_pkg::DATA_WORDS;

  if (NUM_BUF > mbs_pkg::MAX_BUF || NUM_BUF > (1 << BUF_W) || NUM_BUF < 1) begin : g_bad
    $error("mbs_engine: NUM_BUF does not fit");
  end

  logic [15:0] hdr_mem [NUM_BUF];
  logic [15:0] len_mem [NUM_BUF];
  logic [10:0] crc_mem [NUM_BUF];
  logic [8:0] sts_mem [NUM_BUF];
  logic [15:0] data_mem [NUM_BUF][DW];
  mbs_pkg::mbs_kind_t kind_reg [NUM_BUF];
  logic [15:0] stage [DW];
  logic [4:0] stage_cnt_reg;
  logic [6:0] spl_reg;
  logic [6:0] dpl_reg;
  logic [15:0] sync_slot_register;
  logic [15:0] rdata_reg;
  logic spl_irq_reg, dpl_irq_reg;
  logic [3:0] host_didx;
  logic host_data_word, host_wr_buf, upd, upd_tx, upd_fifo, frame_good, store_ok, hdr_ok;
  logic [8:0] rx_status;
  mbs_pkg::mbs_kind_t upd_kind, host_kind, tx_kind;

  ////////////////////////////////////////////////////////////////////////////
  // decode of host and engine accesses
  assign host_data_word = (mb.word >= mbs_pkg::W_DATA0) && (mb.word < mbs_pkg::W_STS);
  assign host_didx = 4'(mb.word - mbs_pkg::W_DATA0);
  assign host_wr_buf = mb.wr && !mb.cfg && (32'(mb.buf_sel) < NUM_BUF);
  assign host_kind = kind_reg[mb.buf_sel];
  assign upd = pe_slot_done && pe_buf_hit && (32'(pe_buf) < NUM_BUF);
  assign upd_kind = kind_reg[pe_buf];
  assign upd_tx = (upd_kind == mbs_pkg::MBS_TXS) || (upd_kind == mbs_pkg::MBS_TXD);
  assign upd_fifo = upd_kind == mbs_pkg::MBS_FIFO;
  assign tx_kind = kind_reg[pe_tx_buf];

  // slot outcome to status flags; no activity yields only the channel bit
  assign hdr_ok = pe_frame_seen && pe_syntax_ok;
  assign frame_good = hdr_ok && pe_content_ok;
  assign rx_status[8] = pe_channel; // R21 R15
  assign rx_status[7] = frame_good || pe_symbol_ok; // R20
  assign rx_status[6] = hdr_ok && pe_hdr_sync; // R19
  assign rx_status[5] = hdr_ok && pe_hdr_null; // R19
  assign rx_status[4] = hdr_ok && pe_hdr_startup; // R19
  assign rx_status[3] = pe_frame_seen && !pe_syntax_ok; // R18
  assign rx_status[2] = hdr_ok && !pe_content_ok; // R18
  assign rx_status[1] = pe_boundary; // R17
  assign rx_status[0] = 1'b0;

  // null frames are not stored; fifo also needs the filters to agree
  assign store_ok = frame_good && !pe_hdr_null &&
    (!upd_fifo || (pe_acc_pass && !pe_rej_hit && !pe_ded_match)); // R12 R22

  ////////////////////////////////////////////////////////////////////////////
  // payload staging: held apart so a bad frame never touches the buffer
  always_ff @(posedge clk) begin
    if (reset || pe_slot_done) begin
      stage_cnt_reg <= 5'h00;
    end else if (pe_rx_word_valid && stage_cnt_reg < 5'(DW)) begin // R4
      stage[stage_cnt_reg[3:0]] <= pe_rx_word;
      stage_cnt_reg <= stage_cnt_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration words written by the host
  always_ff @(posedge clk) begin
    if (reset) begin
      spl_reg <= mbs_pkg::SPL_RESET;
      dpl_reg <= mbs_pkg::DPL_RESET;
      sync_slot_register <= mbs_pkg::SYNC_RESET;
      for (int i = 0; i < NUM_BUF; i++) kind_reg[i] <= mbs_pkg::MBS_RX;
    end else if (mb.wr && mb.cfg) begin
      if (mb.word == mbs_pkg::C_SPL) spl_reg <= mb.wdata[6:0];
      if (mb.word == mbs_pkg::C_DPL) dpl_reg <= mb.wdata[6:0];
      if (mb.word == mbs_pkg::C_SYNC) sync_slot_register <= mb.wdata;
      for (int i = 0; i < NUM_BUF; i++) begin
        if (mb.word == mbs_pkg::C_KIND0 + 5'(i)) kind_reg[i] <= mbs_pkg::mbs_kind_t'(mb.wdata[1:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer fields: host writes first, the slot update wins on a clash
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        hdr_mem[i] <= 16'h0000;
        len_mem[i] <= 16'h0000;
        crc_mem[i] <= 11'h000;
      end
    end else begin
      if (host_wr_buf) begin
        if (mb.word == mbs_pkg::W_HDR) hdr_mem[mb.buf_sel] <= mb.wdata;
        if (mb.word == mbs_pkg::W_LEN) len_mem[mb.buf_sel] <= mb.wdata; // R1
        if (mb.word == mbs_pkg::W_CRC) crc_mem[mb.buf_sel] <= mb.wdata[10:0]; // R7
        if (host_data_word) data_mem[mb.buf_sel][host_didx] <= mb.wdata;
      end
      if (upd && !upd_tx && store_ok) begin // R13 R8
        hdr_mem[pe_buf] <= {1'b0, pe_hdr_pp, 1'b1, pe_hdr_sync, pe_hdr_startup, pe_hdr_id};
        len_mem[pe_buf] <= {2'b00, pe_hdr_cycle, 1'b0, pe_hdr_len}; // R1
        crc_mem[pe_buf] <= pe_hdr_crc; // R6
        for (int i = 0; i < DW; i++) begin
          data_mem[pe_buf][i] <= stage[i]; // R4
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot status words; the whole update lands on the slot_done edge
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_BUF; i++) sts_mem[i] <= mbs_pkg::STS_RESET;
    end else if (upd) begin
      if (upd_tx) begin
        sts_mem[pe_buf][mbs_pkg::S_TX_CONFLICT_FLAG] <= pe_tx_conflict; // R11 R16
      end else begin
        sts_mem[pe_buf] <= {rx_status[8:1], sts_mem[pe_buf][mbs_pkg::S_TX_CONFLICT_FLAG]}; // R11 R10
      end
    end
  end

  // update finished one clock after slot end, well inside a macrotick
  always_ff @(posedge clk) begin
    pe_update_done <= !reset && pe_slot_done; // R14
  end

  ////////////////////////////////////////////////////////////////////////////
  // length checks on host writes to transmit buffers
  always_ff @(posedge clk) begin
    spl_irq_reg <= !reset && host_wr_buf && mb.word == mbs_pkg::W_LEN &&
      host_kind == mbs_pkg::MBS_TXS && mb.wdata[6:0] != spl_reg; // R2
    dpl_irq_reg <= !reset && host_wr_buf && mb.word == mbs_pkg::W_LEN &&
      host_kind == mbs_pkg::MBS_TXD && mb.wdata[6:0] > dpl_reg; // R3
  end
  assign mb.static_length_mismatch_irq = spl_irq_reg;
  assign mb.dynamic_length_excess_irq = dpl_irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // host read port; reserved status bits read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
    end else if (mb.rd) begin
      rdata_reg <= 16'h0000;
      if (mb.cfg) begin
        if (mb.word == mbs_pkg::C_SPL) rdata_reg <= {9'h000, spl_reg};
        if (mb.word == mbs_pkg::C_DPL) rdata_reg <= {9'h000, dpl_reg};
        if (mb.word == mbs_pkg::C_SYNC) rdata_reg <= sync_slot_register;
        for (int i = 0; i < NUM_BUF; i++) begin
          if (mb.word == mbs_pkg::C_KIND0 + 5'(i)) rdata_reg <= {14'h0000, kind_reg[i]};
        end
      end else if (32'(mb.buf_sel) < NUM_BUF) begin
        if (mb.word == mbs_pkg::W_HDR) rdata_reg <= hdr_mem[mb.buf_sel];
        if (mb.word == mbs_pkg::W_LEN) rdata_reg <= len_mem[mb.buf_sel];
        if (mb.word == mbs_pkg::W_CRC) rdata_reg <= {5'h00, crc_mem[mb.buf_sel]};
        if (host_data_word) rdata_reg <= data_mem[mb.buf_sel][host_didx];
        if (mb.word == mbs_pkg::W_STS) rdata_reg <= {7'h00, sts_mem[mb.buf_sel]}; // R10
      end
    end
  end
  assign mb.rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // transmit side: buffer sync/startup bits are ignored, the sync slot decides
  always_ff @(posedge clk) begin
    if (reset) begin
      pe_tx_sync <= 1'b0;
      pe_tx_startup <= 1'b0;
      pe_tx_data <= 16'h0000;
      pe_tx_len <= 7'h00;
      pe_tx_crc <= 11'h000;
    end else begin
      pe_tx_sync <= pe_slot_id == sync_slot_register[10:0]; // R9
      pe_tx_startup <= pe_slot_id == sync_slot_register[10:0] &&
        sync_slot_register[mbs_pkg::SYNC_SUP_BIT]; // R9
      if (pe_tx_rd && 32'(pe_tx_buf) < NUM_BUF) begin
        pe_tx_data <= data_mem[pe_tx_buf][pe_tx_word];
        pe_tx_crc <= crc_mem[pe_tx_buf]; // R7
        // a static transmit buffer goes out at the configured static length, capped at MAX_LEN
        if (tx_kind == mbs_pkg::MBS_TXS) begin
          pe_tx_len <= (spl_reg > mbs_pkg::MAX_LEN) ? mbs_pkg::MAX_LEN : spl_reg;
        end else begin
          pe_tx_len <= (len_mem[pe_tx_buf][6:0] > mbs_pkg::MAX_LEN) ?
            mbs_pkg::MAX_LEN : len_mem[pe_tx_buf][6:0]; // R4
        end
      end
    end
  end
endmodule // mbs_engine
`default_nettype wire

/* hw/mbs_host.sv */
// host controller end: forwards software accesses and builds transmit headers
// assumes software uses the plain strobe port; bit 9 of the address selects own registers
`default_nettype none
module mbs_host #(
  parameter int BUF_W = 3
) (
  input wire logic clk,
  input wire logic reset,
  mbs_if.host mb,
  input wire logic [9:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata
);
  if (BUF_W > 3 || BUF_W < 1) begin : g_bad
    $error("mbs_host: BUF_W must be 1 to 3");
  end

  typedef enum logic [2:0] {
    MBS_IDLE = 3'b000,
    MBS_CRC = 3'b001,
    MBS_WHDR = 3'b010,
    MBS_WLEN = 3'b011,
    MBS_WCRC = 3'b100
  } mbs_hstate_t;

  mbs_hstate_t state_reg;
  logic [15:0] hid_reg;
  logic [6:0] hlen_reg;
  logic [BUF_W-1:0] tgt_reg;
  logic [10:0] crc_val;
  logic crc_busy, crc_done, spl_err_reg, dpl_err_reg, fwd_rd_reg, fwd, own, go, idle;
  logic [15:0] own_rdata_reg;

  assign idle = state_reg == MBS_IDLE;
  assign fwd = !sw_addr[9] && idle; // forwarded access refused while a header is built
  assign own = sw_addr[9];
  assign go = sw_wr && own && sw_addr[8:0] == mbs_pkg::R_HGO && idle;

  ////////////////////////////////////////////////////////////////////////////
  // the host computes the check code; the device will not verify it
  mbs_header_check_code u_crc (
    .clk(clk),
    .reset(reset),
    .start(go),
    .sync_bit(hid_reg[15]),
    .startup_bit(hid_reg[14]),
    .frame_id(hid_reg[10:0]),
    .payload_word_count(hlen_reg),
    .busy(crc_busy),
    .done(crc_done),
    .header_check_code(crc_val)
  ); // R7 R5

  // header build sequence: check code, then header, length and code words
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= MBS_IDLE;
    end else begin
      unique case (state_reg)
        MBS_IDLE: if (go) state_reg <= MBS_CRC;
        MBS_CRC: if (crc_done) state_reg <= MBS_WHDR;
        MBS_WHDR: state_reg <= MBS_WLEN;
        MBS_WLEN: state_reg <= MBS_WCRC;
        MBS_WCRC: state_reg <= MBS_IDLE;
        default: state_reg <= MBS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // own registers; set by the device beats a clear by software
  always_ff @(posedge clk) begin
    if (reset) begin
      hid_reg <= 16'h0000;
      hlen_reg <= 7'h00;
      tgt_reg <= '0;
      spl_err_reg <= 1'b0;
      dpl_err_reg <= 1'b0;
    end else begin
      if (sw_wr && own && idle && sw_addr[8:0] == mbs_pkg::R_HID) hid_reg <= sw_wdata;
      if (sw_wr && own && idle && sw_addr[8:0] == mbs_pkg::R_HLEN) hlen_reg <= sw_wdata[6:0]; // R1
      if (go) tgt_reg <= sw_wdata[BUF_W-1:0];
      spl_err_reg <= mb.static_length_mismatch_irq ||
        (spl_err_reg && !(sw_wr && own && sw_addr[8:0] == mbs_pkg::R_HSTAT && sw_wdata[1]));
      dpl_err_reg <= mb.dynamic_length_excess_irq ||
        (dpl_err_reg && !(sw_wr && own && sw_addr[8:0] == mbs_pkg::R_HSTAT && sw_wdata[2]));
    end
  end

  // reads of own registers, and which source the read data come from
  always_ff @(posedge clk) begin
    if (reset) begin
      own_rdata_reg <= 16'h0000;
      fwd_rd_reg <= 1'b0;
    end else begin
      fwd_rd_reg <= sw_rd && fwd;
      own_rdata_reg <= 16'h0000;
      if (sw_rd && own) begin
        unique case (sw_addr[8:0])
          mbs_pkg::R_HID: own_rdata_reg <= hid_reg;
          mbs_pkg::R_HLEN: own_rdata_reg <= {9'h000, hlen_reg};
          mbs_pkg::R_HGO: own_rdata_reg <= {{(16 - BUF_W){1'b0}}, tgt_reg};
          mbs_pkg::R_HSTAT: own_rdata_reg <= {13'h0000, dpl_err_reg, spl_err_reg, !idle};
          mbs_pkg::R_HEADER_CHECK_CODE: own_rdata_reg <= {5'h00, crc_val};
          default: own_rdata_reg <= 16'h0000;
        endcase
      end
    end
  end
  assign sw_rdata = fwd_rd_reg ? mb.rdata : own_rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // link drive: the build sequence owns the link while it runs
  always_comb begin
    mb.cfg = sw_addr[8];
    mb.buf_sel = sw_addr[5 +: BUF_W];
    mb.word = sw_addr[4:0];
    mb.wdata = sw_wdata;
    mb.wr = sw_wr && fwd;
    mb.rd = sw_rd && fwd;
    if (!idle && !crc_busy && state_reg != MBS_CRC) begin
      mb.cfg = 1'b0;
      mb.buf_sel = tgt_reg;
      mb.wr = 1'b1;
      mb.rd = 1'b0;
      if (state_reg == MBS_WHDR) begin
        mb.word = mbs_pkg::W_HDR;
        mb.wdata = {3'b000, hid_reg[15], hid_reg[14], hid_reg[10:0]};
      end else if (state_reg == MBS_WLEN) begin
        mb.word = mbs_pkg::W_LEN;
        mb.wdata = {9'h000, hlen_reg};
      end else begin
        mb.word = mbs_pkg::W_CRC;
        mb.wdata = {5'h00, crc_val}; // R7
      end
    end
  end
endmodule // mbs_host
`default_nettype wire

/* sim/mbs_link_props.sv */
// checker on the buffer link between the host end and the device end
// assumes it is instantiated beside the link, fed with the link signals
`default_nettype none
module mbs_link_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg,
  input wire logic [2:0] buf_sel,
  input wire logic [4:0] word,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic static_length_mismatch_irq,
  input wire logic dynamic_length_excess_irq
);
  logic [6:0] spl_reg, dpl_reg;
  logic [1:0] kind_reg [8];
  logic lw, sbad, dbad;
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the config words; no view inside the device needed
  always_ff @(posedge clk) begin
    if (reset) begin
      spl_reg <= mbs_pkg::SPL_RESET;
      dpl_reg <= mbs_pkg::DPL_RESET;
      for (int i = 0; i < 8; i++) kind_reg[i] <= 2'h0;
    end else if (wr && cfg) begin
      if (word == mbs_pkg::C_SPL) spl_reg <= wdata[6:0];
      if (word == mbs_pkg::C_DPL) dpl_reg <= wdata[6:0];
      if (word >= mbs_pkg::C_KIND0 && word < 5'h0b) kind_reg[3'(word - 5'h03)] <= wdata[1:0];
    end
  end
  // length writes into transmit buffers and whether they break the setting
  assign lw = wr && !cfg && word == mbs_pkg::W_LEN;
  assign sbad = lw && kind_reg[buf_sel] == mbs_pkg::MBS_TXS && wdata[6:0] != spl_reg;
  assign dbad = lw && kind_reg[buf_sel] == mbs_pkg::MBS_TXD && wdata[6:0] > dpl_reg;
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_SPL_SET: assert property (sbad |=> static_length_mismatch_irq)
    else $error("static length pulse missing");
  AST_SPL_CLR: assert property (!sbad |=> !static_length_mismatch_irq)
    else $error("static length pulse unasked");
  AST_DPL_SET: assert property (dbad |=> dynamic_length_excess_irq)
    else $error("dynamic length pulse missing");
  AST_DPL_CLR: assert property (!dbad |=> !dynamic_length_excess_irq)
    else $error("dynamic length pulse unasked");
  AST_STS_RSV: assert property (rd && !cfg && word == mbs_pkg::W_STS |=> rdata[15:9] == 7'h00)
    else $error("status reserved bits set");
  AST_UNMAP: assert property (rd && !cfg && word > mbs_pkg::W_STS |=> rdata == 16'h0000)
    else $error("unmapped word not zero");
  AST_SPL_RB: assert property (rd && cfg && word == mbs_pkg::C_SPL |=> rdata[6:0] == $past(spl_reg))
    else $error("static length readback wrong");
  AST_DPL_RB: assert property (rd && cfg && word == mbs_pkg::C_DPL |=> rdata[6:0] == $past(dpl_reg))
    else $error("dynamic limit readback wrong");
endmodule // mbs_link_props
`default_nettype wire

/* sim/msg_buffer_slot_status_tb_top.sv */
// bench: both ends joined by the link; software and engine sides driven here
// assumes one clock and a synchronous active high reset
`default_nettype none
module msg_buffer_slot_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, sw_wr, sw_rd, pe_tx_sync, pe_tx_startup, pe_rx_word_valid, pe_slot_done;
  logic pe_buf_hit, pe_channel, pe_frame_seen, pe_syntax_ok, pe_content_ok, pe_boundary;
  logic pe_tx_conflict, pe_hdr_null, pe_hdr_sync, pe_hdr_startup, pe_acc_pass, pe_rej_hit;
  logic pe_tx_rd, pe_update_done, pe_ded_match;
  logic [2:0] pe_buf, pe_tx_buf;
  logic [3:0] pe_tx_word;
  logic [6:0] pe_hdr_len, pe_tx_len;
  logic [9:0] sw_addr;
  logic [10:0] pe_slot_id, pe_hdr_crc, pe_tx_crc;
  logic [15:0] sw_wdata, sw_rdata, pe_rx_word, pe_tx_data;
  int error_cnt, num_checks;
  mbs_if lnk ();
  mbs_host mbs_host_i (.clk, .reset, .mb(lnk), .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
  mbs_engine mbs_engine_i (.clk, .reset, .mb(lnk), .pe_slot_id, .pe_tx_sync, .pe_tx_startup,
    .pe_rx_word_valid, .pe_rx_word, .pe_slot_done, .pe_buf_hit, .pe_buf, .pe_channel,
    .pe_frame_seen, .pe_symbol_ok(1'b0), .pe_syntax_ok, .pe_content_ok, .pe_boundary,
    .pe_tx_conflict, .pe_hdr_pp(1'b0), .pe_hdr_null, .pe_hdr_sync, .pe_hdr_startup,
    .pe_hdr_id(11'h000), .pe_hdr_cycle(6'h00), .pe_hdr_len, .pe_hdr_crc, .pe_acc_pass,
    .pe_rej_hit, .pe_ded_match, .pe_tx_rd, .pe_tx_buf, .pe_tx_word, .pe_tx_data,
    .pe_tx_len, .pe_tx_crc, .pe_update_done);
  mbs_link_props props_i (.clk, .reset, .cfg(lnk.cfg), .buf_sel(lnk.buf_sel), .word(lnk.word),
    .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata),
    .static_length_mismatch_irq(lnk.static_length_mismatch_irq),
    .dynamic_length_excess_irq(lnk.dynamic_length_excess_irq));
  ////////////////////////////////////////////////////////////////////////////////
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one-cycle strobes, a gap edge between calls
  task wr_sw(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    {sw_addr, sw_wdata, sw_wr} <= {a, d, 1'b1};
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task chk_rd(input logic [9:0] a, input logic [15:0] exp);
    @(posedge clk);
    {sw_addr, sw_rd} <= {a, 1'b1};
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    chk(sw_rdata, exp);
  endtask
  // one slot outcome; update shows the cycle after slot end
  task slot(input logic [2:0] b, input logic ch, fr, syn, cnf, bnd);
    @(posedge clk);
    {pe_buf, pe_channel, pe_frame_seen, pe_syntax_ok, pe_tx_conflict, pe_boundary,
      pe_slot_done, pe_buf_hit} <= {b, ch, fr, syn, cnf, bnd, 2'b11};
    @(posedge clk);
    pe_slot_done <= 1'b0;
    @(negedge clk);
    chk({15'h0, pe_update_done}, 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk_rd(10'h100, 16'h0008);
    chk_rd(10'h101, 16'h0010);
    chk_rd(10'h013, 16'h0000);
    chk_rd(10'h01f, 16'h0000);
  endtask
  // buffer 1 static tx, buffer 2 dynamic tx; boundary lengths then one under the static, one over the dynamic
  task t_len;
    wr_sw(10'h104, 16'h0002);
    wr_sw(10'h105, 16'h0003);
    wr_sw(10'h021, 16'h0008);
    wr_sw(10'h041, 16'h0010);
    chk_rd(10'h203, 16'h0000);
    wr_sw(10'h021, 16'h0007);
    wr_sw(10'h041, 16'h0011);
    chk_rd(10'h203, 16'h0006);
  endtask
  task t_rx;
    @(posedge clk);
    {pe_rx_word_valid, pe_rx_word} <= {1'b1, 16'hbeef};
    @(posedge clk);
    pe_rx_word_valid <= 1'b0;
    slot(3'h0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    chk_rd(10'h013, 16'h01d2);
    chk_rd(10'h001, 16'h0003);
    chk_rd(10'h002, 16'h02a5);
    chk_rd(10'h000, 16'h3800);
    chk_rd(10'h003, 16'hbeef);
    pe_hdr_crc <= 11'h155;
    slot(3'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    chk_rd(10'h013, 16'h0008);
    chk_rd(10'h002, 16'h02a5);
    {pe_hdr_sync, pe_hdr_startup} <= 2'b00;
    slot(3'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    chk_rd(10'h013, 16'h0100);
  endtask
  // buffer 3 as fifo: a dedicated match keeps the frame out
  task t_fifo;
    wr_sw(10'h106, 16'h0001);
    pe_ded_match <= 1'b1;
    slot(3'h3, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    chk_rd(10'h061, 16'h0000);
    pe_ded_match <= 1'b0;
    slot(3'h3, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    chk_rd(10'h061, 16'h0003);
  endtask
  // static tx length comes from the static setting, not from the buffer word
  task t_tx;
    slot(3'h1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    chk_rd(10'h033, 16'h0001);
    @(posedge clk);
    {pe_tx_rd, pe_tx_buf} <= {1'b1, 3'h1};
    @(posedge clk);
    pe_tx_rd <= 1'b0;
    @(negedge clk);
    chk({9'h0, pe_tx_len}, 16'h0008);
  endtask
  task t_sync;
    wr_sw(10'h102, 16'h8005);
    repeat (3) @(negedge clk);
    chk({14'h0, pe_tx_sync, pe_tx_startup}, 16'h0003);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    {sw_wr, sw_rd, sw_addr, sw_wdata, pe_rx_word_valid, pe_rx_word, pe_slot_done} = '0;
    {pe_buf_hit, pe_buf, pe_channel, pe_frame_seen, pe_syntax_ok, pe_boundary} = '0;
    {pe_tx_conflict, pe_hdr_null, pe_rej_hit, pe_tx_rd, pe_tx_buf, pe_tx_word, pe_ded_match} = '0;
    {pe_hdr_sync, pe_hdr_startup, pe_content_ok, pe_acc_pass} = 4'hf;
    {pe_hdr_len, pe_hdr_crc, pe_slot_id} = {7'h03, 11'h2a5, 11'h005};
    error_cnt = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_len();
    t_rx();
    t_fifo();
    t_tx();
    t_sync();
    stop_test();
  end
endmodule // msg_buffer_slot_status_tb_top
`default_nettype wire
